// [hdl/tecp_prescaler.sv]
// Free running prescaler giving a one-cycle tick at the selected division
`timescale 1ns/1ns
`default_nettype none
module tecp_prescaler #(
  parameter int WIDTH = 7
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic osc_tick,
  input wire logic [2:0] rate,
  output logic tick
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
  } tecp_pre_t;

  tecp_pre_t p_q;
  tecp_pre_t p_d;
  logic [WIDTH-1:0] mask;

  // Code 000 divides by 128, code 111 by 1
  function automatic logic [WIDTH-1:0] rate_mask(input logic [2:0] code);
    rate_mask = WIDTH'((8'h80 >> code) - 8'h01);
  endfunction : rate_mask

  always_comb begin
    p_d = p_q;
    mask = rate_mask(rate);
    if (osc_tick) begin
      p_d.count = WIDTH'(p_q.count + 1'b1);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      p_q <= '0;
    end else begin
      p_q <= p_d;
    end
  end

  assign tick = osc_tick & ((p_q.count & mask) == mask);
endmodule : tecp_prescaler
`default_nettype wire

// [hdl/tecp_sync.sv]
// Two-stage synchroniser with falling edge detection on the stable stage
`timescale 1ns/1ns
`default_nettype none
module tecp_sync (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic pin_in,
  output logic level_out,
  output logic fall_pulse
);
  typedef struct packed {
    logic meta;
    logic stable;
    logic last;
  } tecp_sync_t;

  tecp_sync_t s_q;
  tecp_sync_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.meta = pin_in;
    s_d.stable = s_q.meta;
    s_d.last = s_q.stable;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      // Idle high so that release of reset does not fake a falling edge
      s_q <= '{meta: 1'b1, stable: 1'b1, last: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign level_out = s_q.stable;
  assign fall_pulse = s_q.last & ~s_q.stable;
endmodule : tecp_sync
`default_nettype wire

// [hdl/tecp_top.sv]
// Eight-bit timer with event counter, continuous PWM and one-pulse PWM
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module tecp_top #(
  parameter int PRESCALE_WIDTH = 7
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic high_osc_tick,
  input wire logic low_osc_tick,
  input wire logic event_input_pin,
  input wire logic pin_irq_request,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  output logic pwm_pin_o,
  output logic pwm_pin_oe,
  output logic pwm_active,
  output logic overflow_irq,
  output logic overflow_pulse,
  output logic pin_irq_flag,
  output logic event_wake_enable
);

  // ==========================================================
  // State
  typedef struct packed {
    tecp_pkg::tecp_mode_t mode;
    logic [7:0] count_value;
    logic [7:0] reload_stage;
    logic [7:0] reload_value;
    logic [7:0] duty_stage;
    logic [7:0] duty_compare;
    logic overflow_flag;
    logic overflow_irq_enable;
    logic clock_mode_select;
    logic pin_irq_flag;
    logic pwm_level;
    logic pwm_live;
    logic started;
    logic overflow_pulse;
    logic [7:0] rdata;
  } tecp_state_t;

  tecp_state_t s_q;
  tecp_state_t s_d;
  tecp_pkg::tecp_bus_t bus;
  logic event_fall;
  logic osc_tick;
  logic pre_tick;
  logic count_tick;
  logic wrap;
  logic pwm_mode;
  logic [7:0] mode_byte;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  function automatic logic hit(input tecp_pkg::tecp_bus_t b, input logic [2:0] a);
    hit = b.wr && (b.addr == a);
  endfunction : hit

  // ==========================================================
  // Clock sources
  tecp_sync u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .pin_in(event_input_pin),
    .level_out(),
    .fall_pulse(event_fall)
  );

  assign osc_tick = s_q.clock_mode_select ? low_osc_tick : high_osc_tick;

  tecp_prescaler #(
    .WIDTH(PRESCALE_WIDTH)
  ) u_pre (
    .clock(clock),
    .reset_n(reset_n),
    .osc_tick(osc_tick),
    .rate(s_q.mode.rate),
    .tick(pre_tick)
  );

  assign count_tick = s_q.mode.ext_clock_select ? event_fall : pre_tick;
  assign wrap = s_q.mode.enable && s_q.started && count_tick
    && (s_q.count_value == tecp_pkg::COUNT_FULL);
  assign pwm_mode = s_q.mode.enable && s_q.mode.pwm_output_enable;
  assign mode_byte = {s_q.mode.enable, s_q.mode.rate, s_q.mode.ext_clock_select, 1'b0,
    s_q.mode.one_pulse_select, s_q.mode.pwm_output_enable};

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.overflow_pulse = 1'b0;
    s_d.rdata = 8'h00;

    // Register writes
    if (hit(bus, tecp_pkg::ADDR_MODE)) begin
      s_d.mode.enable = bus.wdata[tecp_pkg::MODE_ENABLE_BIT];
      s_d.mode.rate = bus.wdata[tecp_pkg::MODE_RATE_LSB +: 3];
      s_d.mode.ext_clock_select = bus.wdata[tecp_pkg::MODE_EXT_BIT];
      s_d.mode.one_pulse_select = bus.wdata[tecp_pkg::MODE_PULSE_BIT];
      s_d.mode.pwm_output_enable = bus.wdata[tecp_pkg::MODE_PWM_BIT];
    end
    if (hit(bus, tecp_pkg::ADDR_COUNT)) begin
      s_d.count_value = bus.wdata;
    end
    if (hit(bus, tecp_pkg::ADDR_RELOAD)) begin
      s_d.reload_stage = bus.wdata;
      if (!s_q.mode.enable) begin
        s_d.reload_value = bus.wdata;
      end
    end
    if (hit(bus, tecp_pkg::ADDR_DUTY)) begin
      s_d.duty_stage = bus.wdata;
      if (!s_q.mode.enable) begin
        s_d.duty_compare = bus.wdata;
      end
    end
    if (hit(bus, tecp_pkg::ADDR_CTRL)) begin
      // Writing zero clears the flag; writing one is ignored
      if (!bus.wdata[tecp_pkg::CTRL_FLAG_BIT]) begin
        s_d.overflow_flag = 1'b0;
      end
      if (!bus.wdata[tecp_pkg::CTRL_PIN_BIT]) begin
        s_d.pin_irq_flag = 1'b0;
      end
      s_d.overflow_irq_enable = bus.wdata[tecp_pkg::CTRL_IEN_BIT];
      s_d.clock_mode_select = bus.wdata[tecp_pkg::CTRL_OSC_BIT];
    end

    // Timer start loads the count from the active reload
    if (!s_q.mode.enable) begin
      s_d.started = 1'b0;
      s_d.pwm_live = 1'b0;
    end else if (!s_q.started) begin
      s_d.started = 1'b1;
      s_d.count_value = s_q.reload_value;
      s_d.pwm_level = s_q.duty_compare > s_q.reload_value;
    end else if (count_tick) begin
      if (wrap) begin
        // New period and duty take effect together at the reload
        s_d.reload_value = s_q.reload_stage;
        s_d.duty_compare = s_q.duty_stage;
        s_d.count_value = s_q.reload_stage;
        s_d.overflow_flag = 1'b1;
        s_d.overflow_pulse = 1'b1;
        s_d.pwm_level = s_q.duty_stage > s_q.reload_stage;
        if (s_q.mode.one_pulse_select && s_q.mode.pwm_output_enable && s_q.pwm_live) begin
          s_d.mode.pwm_output_enable = 1'b0;
          s_d.pwm_live = 1'b0;
        end
      end else begin
        s_d.count_value = 8'(s_q.count_value + 8'h01);
        if (8'(s_q.count_value + 8'h01) == s_q.duty_compare) begin
          s_d.pwm_level = 1'b0;
        end
      end
      // The pin is handed over on the first count edge after enabling
      if (pwm_mode && !s_q.pwm_live && !wrap) begin
        s_d.pwm_live = 1'b1;
      end
    end
    if (!s_d.mode.pwm_output_enable) begin
      s_d.pwm_live = 1'b0;
    end

    // Pin interrupt is blocked while event counting runs
    if (s_q.mode.ext_clock_select) begin
      s_d.pin_irq_flag = 1'b0;
    end else if (pin_irq_request) begin
      s_d.pin_irq_flag = 1'b1;
    end

    // Register reads, answered in the next cycle
    if (bus.rd) begin
      case (bus.addr)
        tecp_pkg::ADDR_MODE: s_d.rdata = mode_byte & tecp_pkg::MODE_MASK;
        tecp_pkg::ADDR_COUNT: s_d.rdata = s_q.count_value;
        tecp_pkg::ADDR_DUTY: s_d.rdata = s_q.duty_stage;
        tecp_pkg::ADDR_CTRL: s_d.rdata = {3'h0, s_q.pin_irq_flag, 1'b0, s_q.clock_mode_select,
          s_q.overflow_irq_enable, s_q.overflow_flag};
        default: s_d.rdata = 8'h00;
      endcase
    end
    // Hardware set wins over a software clear in the same cycle
    if (wrap) begin
      s_d.overflow_flag = 1'b1;
    end
    if (!s_q.mode.ext_clock_select && pin_irq_request) begin
      s_d.pin_irq_flag = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  // Pin falls back to GPIO drive the moment the enable drops
  assign pwm_active = s_q.pwm_live && pwm_mode;
  assign pwm_pin_o = pwm_active ? s_q.pwm_level : gpio_out;
  assign pwm_pin_oe = pwm_active ? 1'b1 : gpio_oe;
  assign overflow_irq = s_q.overflow_flag && s_q.overflow_irq_enable;
  assign overflow_pulse = s_q.overflow_pulse;
  assign pin_irq_flag = s_q.pin_irq_flag;
  assign event_wake_enable = !(s_q.mode.enable && s_q.mode.ext_clock_select);
  assign reg_rdata = s_q.rdata;

endmodule : tecp_top
`default_nettype wire

// [shared/tecp_pkg.sv]
// Package of constants and carrier types for the timer, event counter and PWM block
package tecp_pkg;

  // ==========================================================
  // Register map
  localparam logic [2:0] ADDR_MODE = 3'h0;
  localparam logic [2:0] ADDR_COUNT = 3'h1;
  localparam logic [2:0] ADDR_RELOAD = 3'h2;
  localparam logic [2:0] ADDR_DUTY = 3'h3;
  localparam logic [2:0] ADDR_CTRL = 3'h4;

  // ==========================================================
  // Mode register fields
  localparam int MODE_ENABLE_BIT = 7;
  localparam int MODE_RATE_LSB = 4;
  localparam int MODE_EXT_BIT = 3;
  localparam int MODE_PULSE_BIT = 1;
  localparam int MODE_PWM_BIT = 0;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] MODE_MASK = 8'hfb;

  // Control register fields
  localparam int CTRL_FLAG_BIT = 0;
  localparam int CTRL_IEN_BIT = 1;
  localparam int CTRL_OSC_BIT = 2;
  localparam int CTRL_PIN_BIT = 4;

  // ==========================================================
  // Counter constants
  localparam logic [7:0] COUNT_FULL = 8'hff;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [6:0] PRESCALE_RESET = 7'h00;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tecp_bus_t;

  typedef struct packed {
    logic enable;
    logic [2:0] rate;
    logic ext_clock_select;
    logic one_pulse_select;
    logic pwm_output_enable;
  } tecp_mode_t;

endpackage : tecp_pkg

// [tb/tecp_monitor.sv]
// Port checker for the timer, event counter and PWM block
`timescale 1ns/1ns
`default_nettype none
module tecp_monitor (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  input wire logic pwm_pin_o,
  input wire logic pwm_pin_oe,
  input wire logic pwm_active,
  input wire logic overflow_irq,
  input wire logic overflow_pulse,
  input wire logic pin_irq_flag,
  input wire logic event_wake_enable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Assertions
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its answer cycle");
  a_mode_rsvd: assert property ($past(reg_rd && reg_addr == tecp_pkg::ADDR_MODE)
    |-> reg_rdata[2] == 1'b0) else $error("reserved mode bit reads one");
  a_pin_flag_zero: assert property (!event_wake_enable && $past(!event_wake_enable)
    |-> !pin_irq_flag) else $error("pin flag set while counting events");
  a_wake_by_write: assert property ($changed(event_wake_enable) |-> $past(reg_wr))
    else $error("wake enable moved without a write");
  a_irq_rise: assert property ($rose(overflow_irq) && !$past(reg_wr)
    |-> ##[0:1] overflow_pulse) else $error("interrupt without overflow");
  a_flag_hold: assert property ($fell(overflow_irq) |-> $past(reg_wr))
    else $error("overflow flag dropped by itself");
  a_gpio_pass: assert property (!pwm_active
    |-> pwm_pin_o == gpio_out && pwm_pin_oe == gpio_oe) else $error("pin not back to gpio");
  a_pwm_drive: assert property (pwm_active |-> pwm_pin_oe)
    else $error("pwm pin not driven");
  a_pwm_release: assert property ($fell(pwm_active) && !$past(reg_wr)
    |-> ##[0:1] overflow_pulse) else $error("pwm released off the period end");
  // ==========================================================
  // Coverage
  c_pwm_ovf: cover property (overflow_pulse && pwm_active);
  c_one_pulse: cover property ($fell(pwm_active) && overflow_pulse);
  c_event_ovf: cover property (!event_wake_enable && overflow_pulse);
endmodule : tecp_monitor

bind tecp_top tecp_monitor u_mon (.clock, .reset_n, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
  .gpio_out, .gpio_oe, .pwm_pin_o, .pwm_pin_oe, .pwm_active, .overflow_irq, .overflow_pulse,
  .pin_irq_flag, .event_wake_enable);
`default_nettype wire

// [tb/tecp_partner.sv]
// External pulse source feeding the event pin
`timescale 1ns/1ns
`default_nettype none
module tecp_partner (
  output var logic event_pin
);
  initial event_pin = 1'b1;
  // Edges sit off the clock grid, as an unrelated source would place them
  task automatic pulse(input int cnt);
    repeat (cnt) begin
      #173 event_pin = 1'b0;
      #211 event_pin = 1'b1;
    end
  endtask : pulse
endmodule : tecp_partner
`default_nettype wire

// [tb/tecp_tb_top.sv]
// Self-checking bench for the timer, event counter and PWM block
`timescale 1ns/1ns
`default_nettype none
module tecp_tb_top;
  logic clock, reset_n, pwm_pin_o, pwm_pin_oe, pwm_active, overflow_irq, overflow_pulse;
  logic pin_irq_flag, event_wake_enable, event_input_pin;
  logic reg_wr = 1'b0, reg_rd = 1'b0, irq_on = 1'b0, rd_seen = 1'b0, high_osc_tick = 1'b1;
  logic low_osc_tick = 1'b0, gpio_out = 1'b0, gpio_oe = 1'b0, pin_irq_request = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [7:0] exp_q[$];
  logic [7:0] duty[3] = '{8'hf4, 8'hf0, 8'hff};
  int seed = 12125;
  int num_errors = 0;
  int n_checks = 0;
  int n, hi, tk;

  tecp_top dut (.clock, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .high_osc_tick, .low_osc_tick, .event_input_pin, .pin_irq_request, .gpio_out, .gpio_oe,
    .pwm_pin_o, .pwm_pin_oe, .pwm_active, .overflow_irq, .overflow_pulse, .pin_irq_flag,
    .event_wake_enable);
  tecp_partner p (.event_pin(event_input_pin));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial begin
    #(20000 * 50);
    num_errors++;
    print_verdict();
  end

  always @(posedge clock) begin
    gpio_out <= 1'($random(seed));
    gpio_oe <= 1'($random(seed));
    low_osc_tick <= 1'($random(seed));
    pin_irq_request <= irq_on & 1'($random(seed));
  end

  // ==========================================================
  // Read answers are matched against the oldest note
  always @(posedge clock) begin
    if (rd_seen) check("rdata", 16'(reg_rdata), 16'(exp_q.pop_front()));
    rd_seen <= reg_rd;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(d);
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask : rd

  // Runs to the next overflow, counting cycles and driven high cycles
  task automatic gap();
    hi = 0;
    tk = 0;
    n = 0;
    do begin
      hi += int'(pwm_active & pwm_pin_o);
      tk += int'(low_osc_tick);
      @(posedge clock);
      n++;
    end while (overflow_pulse !== 1'b1 && n < 2000);
  endtask : gap

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  initial begin
    reset_n = 1'b0;
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    for (int a = 0; a < 6; a++) rd(3'(a), 8'h00);
    wr(3'h5, 8'hff);
    rd(3'h5, 8'h00);
    irq_on <= 1'b1;
    repeat (20) @(posedge clock);
    rd(tecp_pkg::ADDR_CTRL, 8'h10);
    // Event counting: two edges to full scale, a third wraps
    wr(tecp_pkg::ADDR_COUNT, 8'hfd);
    wr(tecp_pkg::ADDR_RELOAD, 8'hfd);
    wr(tecp_pkg::ADDR_MODE, 8'h88);
    @(negedge clock);
    check("wake", 16'(event_wake_enable), 16'h0);
    p.pulse(2);
    repeat (5) @(posedge clock);
    rd(tecp_pkg::ADDR_COUNT, 8'hff);
    p.pulse(1);
    repeat (5) @(posedge clock);
    rd(tecp_pkg::ADDR_COUNT, 8'hfd);
    rd(tecp_pkg::ADDR_CTRL, 8'h01);
    irq_on <= 1'b0;
    wr(tecp_pkg::ADDR_MODE, 8'h00);
    wr(tecp_pkg::ADDR_CTRL, 8'h00);
    wr(tecp_pkg::ADDR_COUNT, 8'hfc);
    wr(tecp_pkg::ADDR_RELOAD, 8'hfc);
    for (int c = 0; c < 8; c++) begin
      wr(tecp_pkg::ADDR_MODE, 8'(8'h80 | (c << 4)));
      gap();
      gap();
      check("period", 16'(n), 16'(4 * (128 >> c)));
    end
    for (int i = 0; i < 2; i++) begin
      wr(tecp_pkg::ADDR_RELOAD, 8'(i * 128));
      gap();
      gap();
      check("period", 16'(n), 16'(256 - i * 128));
    end
    // Low oscillator as source: one count per tick that the bench drove
    wr(tecp_pkg::ADDR_CTRL, 8'h04);
    gap();
    gap();
    check("ticks", 16'(tk), 16'h80);
    wr(tecp_pkg::ADDR_CTRL, 8'h00);
    // Continuous PWM, period of sixteen counts
    wr(tecp_pkg::ADDR_MODE, 8'h00);
    wr(tecp_pkg::ADDR_COUNT, 8'hf0);
    wr(tecp_pkg::ADDR_RELOAD, 8'hf0);
    wr(tecp_pkg::ADDR_DUTY, 8'hf4);
    wr(tecp_pkg::ADDR_MODE, 8'h71);
    wr(tecp_pkg::ADDR_MODE, 8'hf1);
    n = 0;
    while (pwm_active !== 1'b1 && n < 50) begin
      @(posedge clock);
      n++;
    end
    check("latency", 16'(n <= 4), 16'h1);
    foreach (duty[i]) begin
      wr(tecp_pkg::ADDR_DUTY, duty[i]);
      gap();
      gap();
      check("period", 16'(n), 16'h10);
      check("high", 16'(hi), 16'(duty[i] > 8'hf0 ? duty[i] - 8'hf0 : 0));
    end
    wr(tecp_pkg::ADDR_CTRL, 8'h02);
    gap();
    @(negedge clock);
    check("irq", 16'(overflow_irq), 16'h1);
    wr(tecp_pkg::ADDR_MODE, 8'hf0);
    @(negedge clock);
    check("active", 16'(pwm_active), 16'h0);
    wr(tecp_pkg::ADDR_MODE, 8'h70);
    wr(tecp_pkg::ADDR_CTRL, 8'h02);
    @(negedge clock);
    check("irq", 16'(overflow_irq), 16'h0);
    // One pulse, armed twice
    wr(tecp_pkg::ADDR_DUTY, 8'hf4);
    for (int k = 0; k < 2; k++) begin
      wr(tecp_pkg::ADDR_COUNT, 8'hf0);
      wr(tecp_pkg::ADDR_MODE, 8'h73);
      wr(tecp_pkg::ADDR_MODE, 8'hf3);
      gap();
      repeat (20) @(posedge clock);
      check("pulse", 16'(hi > 0), 16'h1);
      check("active", 16'(pwm_active), 16'h0);
      rd(tecp_pkg::ADDR_MODE, 8'hf2);
    end
    // Mid-run reset, left until the last read answer has been taken
    repeat (2) @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    rd(tecp_pkg::ADDR_MODE, 8'h00);
    rd(tecp_pkg::ADDR_CTRL, 8'h00);
    repeat (2) @(posedge clock);
    print_verdict();
  end
endmodule : tecp_tb_top
`default_nettype wire
